/* hdl/alu_and_branch_execute.sv */
/*
 * Execute unit for the arithmetic, logic and program-flow operations of
 * an 8-bit core with 32 general registers, with the status flags and
 * the program counter.
 * Assumes a fetch stage that issues one decoded operation at a time
 * while ready is high and an I/O space that answers a bit read in the
 * same cycle as the address is shown.
 */
`timescale 1ns/1ps
`include "exec_consts.svh"

// Function
// - Register sum with carry, five flags, one cycle.
// - Word plus constant, Z C N V S, two cycles.
// - Word minus constant, Z C N V S, two cycles.
// - Register minus register and carry, one cycle.
// - Register minus constant, five flags, one cycle.
// - Register minus constant and carry, one cycle.
// - Constant AND or OR updates Z N V.
// - Register exclusive OR updates Z N V only.
// - Mask clear ANDs with inverted constant.
// - Zero-sign check keeps value, updates Z N V.
// - Relative call jumps PC plus k plus one.
// - Pointer jump loads PC from Z, two cycles.
// - Pointer call loads PC from Z, three cycles.
// - Equal registers skip next, flags untouched.
// - Constant check sets flags, stores nothing.
// - Register bit low skips next instruction.
// - I/O bit high skips next instruction.
// - Flag high branches to PC plus k plus one.
// - Flag low branches to PC plus k plus one.
// - I/O bit skips reach addresses 0x00 to 0x1F.

module alu_and_branch_execute
   import exec_pkg::*;
#(
   parameter int PC_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic issue_in,
   input wire op_t op_in,
   input wire logic [4:0] dst_in,
   input wire logic [4:0] src_in,
   input wire logic [7:0] imm_in,
   input wire logic [11:0] offset_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [4:0] io_addr_in,
   input wire logic next_two_word_in,
   input wire logic [7:0] io_data_in,
   input wire logic load_en_in,
   input wire logic [4:0] load_addr_in,
   input wire logic [7:0] load_data_in,
   input wire logic flags_load_en_in,
   input wire logic [7:0] flags_load_in,
   output logic ready_out,
   output logic done_out,
   output logic call_out,
   output logic [PC_W-1:0] pc_out,
   output logic [PC_W-1:0] ret_addr_out,
   output logic [7:0] flags_out,
   output logic [4:0] io_addr_out,
   output logic wr_en_out,
   output logic [4:0] wr_addr_out,
   output logic [7:0] wr_data_out
);

   // --------
   // Parameter check
   // --------
   if (PC_W <= `OFFSET_W || PC_W > 16) begin : g_pc_w_check
      $error("PC_W must lie above the offset width and at most 16");
   end

   // --------
   // Declarations
   // --------
   state_t state_r;
   op_t op_r;
   logic [4:0] dst_r;
   logic [7:0] imm_r;
   logic [11:0] off_r;
   logic [2:0] bit_r;
   logic two_word_r;
   logic [1:0] left_r;
   logic [7:0] hi_r;
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pend_pc_r;
   logic [7:0] flags_r;
   logic [7:0] pend_flags_r;
   logic pend_call_r;
   logic ready_r;
   logic done_r;
   logic call_r;
   logic [PC_W-1:0] ret_r;
   logic [4:0] io_addr_r;
   logic wr_en_r;
   logic [4:0] wr_addr_r;
   logic [7:0] wr_data_r;

   logic accept;
   logic finish;
   logic [4:0] rd_a_addr;
   logic [4:0] rd_b_addr;
   logic [7:0] rd_a;
   logic [7:0] rd_b;
   alu_kind_t kind;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   logic alu_cin;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_h;
   logic alu_v;
   logic wr8;
   logic word_op;
   logic [7:0] mask;
   logic [1:0] cyc_x;
   logic [PC_W-1:0] pc_x;
   logic call_x;
   logic [16:0] word_res;
   logic word_v;
   logic [7:0] new_flags;
   logic [7:0] flags_nxt;
   logic [PC_W-1:0] pc_seq;
   logic [PC_W-1:0] pc_rel;
   logic [PC_W-1:0] pc_zptr;
   logic rf_we;
   logic [4:0] rf_addr;
   logic [7:0] rf_data;

   // --------
   // Helpers
   // --------
   function automatic logic [7:0] pack_flags(input logic h,
      input logic v, input logic n, input logic z, input logic c);
      logic [7:0] f;
      f = 8'h00;
      f[`FLAG_H] = h;
      f[`FLAG_V] = v;
      f[`FLAG_N] = n;
      f[`FLAG_S] = n ^ v;
      f[`FLAG_Z] = z;
      f[`FLAG_C] = c;
      return f;
   endfunction : pack_flags

   function automatic logic is_word_op(input op_t op);
      return op == word_immediate_sum || op == word_immediate_difference;
   endfunction : is_word_op

   function automatic logic is_pointer_op(input op_t op);
      return op == pointer_jump || op == pointer_call;
   endfunction : is_pointer_op

   // --------
   // Register file and byte ALU
   // --------
   // Load and issue in one cycle would race on the register file, so an
   // issue waits while a load is offered.
   assign accept = state_r == idle && issue_in && !load_en_in;
   assign finish = (state_r == exec && cyc_x == `CYC_ALU)
      || (state_r == hold && left_r == 2'h0);

   always_comb begin
      rd_a_addr = dst_in;
      rd_b_addr = src_in;
      if (is_pointer_op(op_in)) begin
         rd_a_addr = `ZPTR_LO;
         rd_b_addr = `ZPTR_HI;
      end else if (is_word_op(op_in)) begin
         rd_b_addr = {dst_in[4:1], 1'b1};
      end else if (op_in == skip_reg_bit_low
         || op_in == skip_reg_bit_high) begin
         rd_a_addr = src_in;
      end
   end

   always_comb begin
      rf_we = 1'b0;
      rf_addr = load_addr_in;
      rf_data = load_data_in;
      if (state_r == exec && wr8) begin
         rf_we = 1'b1;
         rf_addr = dst_r;
         rf_data = word_op ? word_res[7:0] : alu_res;
      end else if (state_r == hold && finish && word_op) begin
         rf_we = 1'b1;
         rf_addr = {dst_r[4:1], 1'b1};
         rf_data = hi_r;
      end else if (state_r == idle && load_en_in) begin
         rf_we = 1'b1;
      end
   end

   gp_reg_file #(
      .AW(5),
      .WIDTH(8)
   ) u_regs (
      .clk_in(clk_in),
      .rd_a_addr_in(rd_a_addr),
      .rd_b_addr_in(rd_b_addr),
      .rd_a_out(rd_a),
      .rd_b_out(rd_b),
      .we_in(rf_we),
      .wr_addr_in(rf_addr),
      .wr_data_in(rf_data)
   );

   byte_alu u_alu (
      .kind_in(kind),
      .a_in(alu_a),
      .b_in(alu_b),
      .carry_in(alu_cin),
      .res_out(alu_res),
      .c_out(alu_c),
      .h_out(alu_h),
      .v_out(alu_v)
   );

   // --------
   // Operation decode
   // --------
   assign pc_seq = pc_r + PC_W'(1);
   assign pc_rel = pc_r + {{(PC_W - `OFFSET_W){off_r[11]}}, off_r}
      + PC_W'(1);
   assign pc_zptr = PC_W'({rd_b, rd_a});

   always_comb begin
      kind = kind_add;
      alu_a = rd_a;
      alu_b = rd_b;
      alu_cin = 1'b0;
      wr8 = 1'b0;
      word_op = 1'b0;
      mask = `MASK_NONE;
      cyc_x = `CYC_ALU;
      pc_x = pc_seq;
      call_x = 1'b0;
      case (op_r)
         sum: begin
            wr8 = 1'b1;
            mask = `MASK_ZCNVH;
         end
         sum_carry: begin
            alu_cin = flags_r[`FLAG_C];
            wr8 = 1'b1;
            mask = `MASK_ZCNVH;
         end
         word_immediate_sum, word_immediate_difference: begin
            word_op = 1'b1;
            wr8 = 1'b1;
            mask = `MASK_ZCNVS;
            cyc_x = `CYC_WORD;
         end
         difference, reg_diff_flags, diff_flags_carry,
         difference_with_borrow: begin
            kind = kind_sub;
            alu_cin = (op_r == difference_with_borrow
               || op_r == diff_flags_carry) && flags_r[`FLAG_C];
            wr8 = op_r == difference || op_r == difference_with_borrow;
            mask = `MASK_ZCNVH;
         end
         const_difference, const_difference_borrow, diff_flags_const: begin
            kind = kind_sub;
            alu_b = imm_r;
            alu_cin = op_r == const_difference_borrow
               && flags_r[`FLAG_C];
            wr8 = op_r != diff_flags_const;
            mask = `MASK_ZCNVH;
         end
         conjunction, disjunction, exclusive_disjunction, zero_fill: begin
            kind = op_r == conjunction ? kind_and
               : op_r == disjunction ? kind_or : kind_xor;
            alu_b = op_r == zero_fill ? rd_a : rd_b;
            wr8 = 1'b1;
            mask = `MASK_ZNV;
         end
         const_conjunction, const_disjunction, bit_set_mask: begin
            kind = op_r == const_conjunction ? kind_and : kind_or;
            alu_b = imm_r;
            wr8 = 1'b1;
            mask = `MASK_ZNV;
         end
         bit_clear_mask: begin
            kind = kind_and;
            alu_b = `ALL_ONES - imm_r;
            wr8 = 1'b1;
            mask = `MASK_ZNV;
         end
         zero_sign_check: begin
            kind = kind_and;
            alu_b = rd_a;
            mask = `MASK_ZNV;
         end
         ones_inversion: begin
            kind = kind_com;
            wr8 = 1'b1;
            mask = `MASK_ZCNV;
         end
         twos_inversion: begin
            kind = kind_sub;
            alu_a = 8'h00;
            alu_b = rd_a;
            wr8 = 1'b1;
            mask = `MASK_ZCNVH;
         end
         plus_one, minus_one: begin
            kind = op_r == plus_one ? kind_add : kind_sub;
            alu_b = `ONE_BYTE;
            wr8 = 1'b1;
            mask = `MASK_ZNV;
         end
         all_ones_fill: begin
            kind = kind_or;
            alu_b = `ALL_ONES;
            wr8 = 1'b1;
         end
         relative_jump: begin
            cyc_x = `CYC_JUMP;
            pc_x = pc_rel;
         end
         relative_call: begin
            cyc_x = `CYC_CALL;
            pc_x = pc_rel;
            call_x = 1'b1;
         end
         pointer_jump: begin
            cyc_x = `CYC_JUMP;
            pc_x = pc_zptr;
         end
         pointer_call: begin
            cyc_x = `CYC_CALL;
            pc_x = pc_zptr;
            call_x = 1'b1;
         end
         equal_skip, skip_reg_bit_low, skip_reg_bit_high,
         skip_io_bit_low, skip_io_bit_high: begin
            if ((op_r == equal_skip && rd_a == rd_b)
               || (op_r == skip_reg_bit_low && !rd_a[bit_r])
               || (op_r == skip_reg_bit_high && rd_a[bit_r])
               || (op_r == skip_io_bit_low && !io_data_in[bit_r])
               || (op_r == skip_io_bit_high && io_data_in[bit_r])) begin
               cyc_x = two_word_r ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
               pc_x = pc_r + (two_word_r ? PC_W'(3) : PC_W'(2));
            end
         end
         branch_flag_high, branch_flag_low: begin
            if (flags_r[bit_r] == (op_r == branch_flag_high)) begin
               cyc_x = `CYC_BRANCH;
               pc_x = pc_rel;
            end
         end
         default: begin
            mask = `MASK_NONE;
         end
      endcase
   end

   // --------
   // Flag results
   // --------
   // Word operations treat the pair as one 16-bit number; the carry is
   // the seventeenth bit and overflow comes from the high sign bit.
   always_comb begin
      if (op_r == word_immediate_difference) begin
         word_res = {1'b0, rd_b, rd_a} - {9'h000, imm_r};
         word_v = rd_b[7] & ~word_res[15];
      end else begin
         word_res = {1'b0, rd_b, rd_a} + {9'h000, imm_r};
         word_v = ~rd_b[7] & word_res[15];
      end
      if (word_op) begin
         new_flags = pack_flags(1'b0, word_v, word_res[15],
            word_res[15:0] == 16'h0000, word_res[16]);
      end else begin
         new_flags = pack_flags(alu_h, alu_v, alu_res[7],
            alu_res == 8'h00, alu_c);
      end
      flags_nxt = (flags_r & ~mask) | (new_flags & mask);
   end

   // --------
   // Sequencer
   // --------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= idle;
         left_r <= 2'h0;
      end else begin
         case (state_r)
            idle: begin
               if (accept) begin
                  state_r <= exec;
               end
            end
            exec: begin
               if (cyc_x == `CYC_ALU) begin
                  state_r <= idle;
               end else begin
                  state_r <= hold;
                  left_r <= cyc_x - 2'h2;
               end
            end
            hold: begin
               if (left_r == 2'h0) begin
                  state_r <= idle;
               end else begin
                  left_r <= left_r - 2'h1;
               end
            end
            default: state_r <= idle;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         op_r <= sum;
         dst_r <= 5'h00;
         imm_r <= 8'h00;
         off_r <= 12'h000;
         bit_r <= 3'h0;
         two_word_r <= 1'b0;
         io_addr_r <= 5'h00;
      end else if (accept) begin
         op_r <= op_in;
         dst_r <= dst_in;
         imm_r <= imm_in;
         off_r <= offset_in;
         bit_r <= bit_sel_in;
         two_word_r <= next_two_word_in;
         io_addr_r <= io_addr_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hi_r <= 8'h00;
         pend_pc_r <= '0;
         pend_flags_r <= `FLAGS_RESET;
         pend_call_r <= 1'b0;
      end else if (state_r == exec) begin
         hi_r <= word_res[15:8];
         pend_pc_r <= pc_x;
         pend_flags_r <= flags_nxt;
         pend_call_r <= call_x;
      end
   end

   // --------
   // Commit of flags, program counter and call return point
   // --------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pc_r <= '0;
         flags_r <= `FLAGS_RESET;
         ret_r <= '0;
      end else if (finish) begin
         pc_r <= state_r == exec ? pc_x : pend_pc_r;
         flags_r <= state_r == exec ? flags_nxt : pend_flags_r;
         if (state_r == exec ? call_x : pend_call_r) begin
            ret_r <= pc_seq;
         end
      end else if (state_r == idle && flags_load_en_in) begin
         flags_r <= flags_load_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ready_r <= 1'b1;
         done_r <= 1'b0;
         call_r <= 1'b0;
      end else begin
         ready_r <= accept ? 1'b0 : (finish ? 1'b1 : ready_r);
         done_r <= finish;
         call_r <= finish && (state_r == exec ? call_x : pend_call_r);
      end
   end

   // Register writes are mirrored so the bench sees every result byte.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_en_r <= 1'b0;
         wr_addr_r <= 5'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_en_r <= rf_we && state_r != idle;
         wr_addr_r <= rf_addr;
         wr_data_r <= rf_data;
      end
   end

   // --------
   // Outputs
   // --------
   assign ready_out = ready_r;
   assign done_out = done_r;
   assign call_out = call_r;
   assign pc_out = pc_r;
   assign ret_addr_out = ret_r;
   assign flags_out = flags_r;
   assign io_addr_out = io_addr_r;
   assign wr_en_out = wr_en_r;
   assign wr_addr_out = wr_addr_r;
   assign wr_data_out = wr_data_r;

endmodule : alu_and_branch_execute

/* hdl/exec_consts.svh */
/*
 * Constants for the execute block: status bit positions, flag update
 * masks, fixed register indices, widths, reset values and cycle counts.
 * Assumes it is included by bare name after the timescale directive.
 */
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// --------
// Status bit positions
// --------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// --------
// Flag update masks and reset values
// --------
`define MASK_NONE 8'h00
`define MASK_ZCNVH 8'h2F
`define MASK_ZCNVS 8'h1F
`define MASK_ZCNV 8'h0F
`define MASK_ZNV 8'h0E
`define FLAGS_RESET 8'h00

// --------
// Operand constants
// --------
`define ALL_ONES 8'hFF
`define ONE_BYTE 8'h01
`define ZPTR_LO 5'h1E
`define ZPTR_HI 5'h1F
`define OFFSET_W 12

// --------
// Cycle counts
// --------
`define CYC_ALU 2'h1
`define CYC_WORD 2'h2
`define CYC_JUMP 2'h2
`define CYC_CALL 2'h3
`define CYC_SKIP_ONE 2'h2
`define CYC_SKIP_TWO 2'h3
`define CYC_BRANCH 2'h2

`endif

/* hdl/exec_pkg.sv */
/*
 * Types for the execute block: operation codes, byte ALU kinds and
 * sequencer states.
 * Assumes nothing of its surroundings.
 */
package exec_pkg;

   typedef enum logic [5:0] {
      sum, sum_carry, word_immediate_sum, difference, const_difference,
      difference_with_borrow, const_difference_borrow,
      word_immediate_difference, conjunction, const_conjunction,
      disjunction, const_disjunction, exclusive_disjunction,
      ones_inversion, twos_inversion, bit_set_mask, bit_clear_mask,
      plus_one, minus_one, zero_sign_check, zero_fill, all_ones_fill,
      relative_jump, pointer_jump, relative_call, pointer_call,
      equal_skip, reg_diff_flags, diff_flags_carry, diff_flags_const,
      skip_reg_bit_low, skip_reg_bit_high, skip_io_bit_low,
      skip_io_bit_high, branch_flag_high, branch_flag_low
   } op_t;

   typedef enum logic [2:0] {
      kind_add, kind_sub, kind_and, kind_or, kind_xor, kind_com
   } alu_kind_t;

   typedef enum logic [1:0] {
      idle, exec, hold
   } state_t;

endpackage : exec_pkg

/* hdl/gp_reg_file.sv */
/*
 * General register file with two registered read ports and one write
 * port.
 * Assumes the reader takes read data one clock after the address.
 */
`timescale 1ns/1ps

module gp_reg_file #(
   parameter int AW = 5,
   parameter int WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic [AW-1:0] rd_a_addr_in,
   input wire logic [AW-1:0] rd_b_addr_in,
   output logic [WIDTH-1:0] rd_a_out,
   output logic [WIDTH-1:0] rd_b_out,
   input wire logic we_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in
);
   localparam int DEPTH = 2 ** AW;

   if (AW < 1 || WIDTH < 1) begin : g_size_check
      $error("gp_reg_file needs AW and WIDTH of at least one");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];

   // A read in the cycle of a write returns the old word.
   always_ff @(posedge clk_in) begin
      rd_a_out <= mem_r[rd_a_addr_in];
      rd_b_out <= mem_r[rd_b_addr_in];
   end

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
   end

endmodule : gp_reg_file

/* hdl/byte_alu.sv */
/*
 * Combinational byte ALU: sum and difference with carry in, logic
 * operations and inversion, with carry, half carry and overflow.
 * Assumes the caller forms zero, negative and sign from the result.
 */
`timescale 1ns/1ps

module byte_alu
   import exec_pkg::*;
(
   input wire alu_kind_t kind_in,
   input wire logic [7:0] a_in,
   input wire logic [7:0] b_in,
   input wire logic carry_in,
   output logic [7:0] res_out,
   output logic c_out,
   output logic h_out,
   output logic v_out
);
   logic [7:0] r;

   always_comb begin
      r = 8'h00;
      c_out = 1'b0;
      h_out = 1'b0;
      v_out = 1'b0;
      case (kind_in)
         kind_add: begin
            r = a_in + b_in + {7'h00, carry_in};
            c_out = (a_in[7] & b_in[7]) | (b_in[7] & ~r[7])
               | (~r[7] & a_in[7]);
            h_out = (a_in[3] & b_in[3]) | (b_in[3] & ~r[3])
               | (~r[3] & a_in[3]);
            v_out = (a_in[7] & b_in[7] & ~r[7])
               | (~a_in[7] & ~b_in[7] & r[7]);
         end
         kind_sub: begin
            r = a_in - b_in - {7'h00, carry_in};
            c_out = (~a_in[7] & b_in[7]) | (b_in[7] & r[7])
               | (r[7] & ~a_in[7]);
            h_out = (~a_in[3] & b_in[3]) | (b_in[3] & r[3])
               | (r[3] & ~a_in[3]);
            v_out = (a_in[7] & ~b_in[7] & ~r[7])
               | (~a_in[7] & b_in[7] & r[7]);
         end
         kind_and: r = a_in & b_in;
         kind_or: r = a_in | b_in;
         kind_xor: r = a_in ^ b_in;
         kind_com: begin
            r = ~a_in;
            c_out = 1'b1;
         end
         default: r = 8'h00;
      endcase
      res_out = r;
   end

endmodule : byte_alu

/* tb/alu_and_branch_execute_checker.sv */
/* Checker for the execute block: cycle counts, flags and pc.
   Assumes binding to the top module, ports matched by name. */
`timescale 1ns/1ps
module alu_and_branch_execute_checker
   import exec_pkg::*;
#(
   parameter int PC_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic issue_in,
   input wire logic load_en_in,
   input wire op_t op_in,
   input wire logic [11:0] offset_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic ready_out,
   input wire logic done_out,
   input wire logic call_out,
   input wire logic wr_en_out,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic [7:0] flags_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_take;
      issue_in && ready_out && !load_en_in;
   endsequence
   sequence s_late;
      !done_out ##1 done_out;
   endsequence
   AST_ADC: assert property (s_take ##0 op_in == sum_carry
      |-> ##2 done_out) else $error("sum late");
   AST_CONST_DIFFERENCE_BORROW: assert property (s_take ##0
      op_in == const_difference_borrow |-> ##2 done_out && !call_out)
      else $error("borrow late");
   AST_TST: assert property (s_take ##0 op_in == zero_sign_check
      |-> ##2 done_out && !wr_en_out) else $error("test wrote");
   AST_WORD: assert property (s_take ##0
      op_in == word_immediate_difference |-> ##2 s_late)
      else $error("word timing");
   AST_RELATIVE_CALL: assert property (s_take ##0 op_in == relative_call
      |-> ##3 s_late ##0 call_out) else $error("call timing");
   AST_POINTER_JUMP: assert property (s_take ##0 op_in == pointer_jump
      |-> ##2 s_late ##0 !call_out) else $error("jump timing");
   AST_KEEP: assert property (s_take ##0
      op_in inside {relative_call, pointer_call}
      |-> ##2 $stable(flags_out)[*3]) else $error("call flags");
   AST_BRS: assert property (s_take ##0 op_in == branch_flag_high
      && flags_out[bit_sel_in] |-> ##2 s_late ##0 pc_out == $past(pc_out, 3)
      + {{(PC_W-12){$past(offset_in[11], 3)}}, $past(offset_in, 3)} + 1'b1)
      else $error("branch target");
   AST_BRC: assert property (s_take ##0 op_in == branch_flag_low
      && flags_out[bit_sel_in] |-> ##2 done_out) else $error("not taken");
endmodule : alu_and_branch_execute_checker
bind alu_and_branch_execute alu_and_branch_execute_checker
   #(.PC_W(PC_W)) chk (.*);

/* tb/tb_alu_and_branch_execute.sv */
/* Random bench for the execute block, checking results, flags and pc.
   Assumes the design and the checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   mismatches++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_alu_and_branch_execute;
   import exec_pkg::*;
   logic clk_in = 0, rst_in = 1, issue_in = 0, load_en_in = 0, t, we;
   logic flags_load_en_in = 0, next_two_word_in = 0, ready_out, done_out;
   logic call_out, wr_en_out;
   op_t op_in = sum, o;
   logic [4:0] dst_in = 0, src_in = 0, io_addr_in = 0, load_addr_in = 0;
   logic [4:0] io_addr_out, wr_addr_out, d;
   logic [7:0] imm_in = 0, io_data_in = 0, load_data_in = 0, a, b, m, nf;
   logic [7:0] flags_load_in = 0, flags_out, wr_data_out, ef, lo;
   logic [11:0] offset_in = 0;
   logic [2:0] bit_sel_in = 0;
   logic [15:0] pc_out, ret_addr_out, pc = 0, ep, z, r, k;
   logic [16:0] s;
   int mismatches = 0, n_compared = 0, cyc, n, cycles = 0, seed = 32'h7C43;
   op_t ops[20] = '{sum_carry, difference_with_borrow, const_difference,
      const_difference_borrow, diff_flags_const, const_conjunction,
      const_disjunction, exclusive_disjunction, bit_clear_mask,
      zero_sign_check, word_immediate_sum, word_immediate_difference,
      relative_call, pointer_jump, pointer_call, equal_skip,
      skip_reg_bit_low, skip_io_bit_high, branch_flag_high, branch_flag_low};
   alu_and_branch_execute dut (.*);
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cycles == 10000) begin
      mismatches++;
      print_verdict();
   end
   task automatic print_verdict;
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic ld(logic [4:0] x, logic [7:0] v);
      @(negedge clk_in);
      {load_en_in, load_addr_in, load_data_in} = {1'b1, x, v};
      @(negedge clk_in);
      load_en_in = 0;
   endtask : ld
   function automatic logic [15:0] arith(logic [7:0] x, y, logic ci, sub);
      logic [8:0] q;
      logic [4:0] h;
      logic v;
      q = sub ? x - y - ci : x + y + ci;
      h = sub ? x[3:0] - y[3:0] - ci : x[3:0] + y[3:0] + ci;
      v = (sub ? x[7] ^ y[7] : x[7] ~^ y[7]) & (x[7] ^ q[7]);
      return {2'b00, h[4], q[7] ^ v, v, q[7], q[7:0] == 8'h00, q[8], q[7:0]};
   endfunction : arith
   initial begin
      repeat (2) @(negedge clk_in);
      rst_in = 0;
      for (int i = 0; i < 200; i++) begin
         o = ops[i % 20];
         a = 8'($random(seed));
         // Runs with index bit 5 set, 96 of 200, use equal operands so both skip outcomes occur.
         b = i[5] ? a : 8'($random(seed));
         d = 5'(2 * ({$random(seed)} % 15));
         z = 16'($random(seed));
         ef = 8'($random(seed));
         ld(d, a);
         ld(d | 5'h01, b);
         ld(5'h1E, z[7:0]);
         ld(5'h1F, z[15:8]);
         @(negedge clk_in);
         {flags_load_en_in, flags_load_in} = {1'b1, ef};
         @(negedge clk_in);
         flags_load_en_in = 0;
         {dst_in, src_in, imm_in} = {d, d | 5'h01, 8'($random(seed))};
         {next_two_word_in, offset_in, bit_sel_in, io_addr_in, io_data_in} =
            29'($random(seed));
         op_in = o;
         issue_in = 1;
         @(negedge clk_in);
         issue_in = 0;
         cyc = 0;
         while (done_out !== 1 && cyc < 9) begin
            @(negedge clk_in);
            if (cyc == 0) lo = wr_data_out;
            cyc++;
         end
         {m, we, n, ep, r} = {8'h2F, 1'b1, 32'd1, pc + 16'h0001, 16'h0000};
         k = {{4{offset_in[11]}}, offset_in} + 16'h0001;
         case (o)
            sum_carry, difference_with_borrow:
               {nf, r[7:0]} = arith(a, b, ef[0], o != sum_carry);
            const_difference, diff_flags_const, const_difference_borrow: begin
               t = o == const_difference_borrow;
               {nf, r[7:0]} = arith(a, imm_in, t & ef[0], 1);
               we = o != diff_flags_const;
            end
            const_conjunction: r = {8'h00, a & imm_in};
            const_disjunction: r = {8'h00, a | imm_in};
            exclusive_disjunction: r = {8'h00, a ^ b};
            bit_clear_mask: r = {8'h00, a & ~imm_in};
            zero_sign_check: {we, r} = {9'h000, a};
            word_immediate_sum, word_immediate_difference: begin
               t = o == word_immediate_sum;
               s = t ? {b, a} + imm_in : {b, a} - imm_in;
               r = s[15:0];
               t = t ? ~b[7] & r[15] : b[7] & ~r[15];
               {n, m} = {32'd2, 8'h1F};
               nf = {3'h0, r[15] ^ t, t, r[15], r == 16'h0000, s[16]};
            end
            relative_call, pointer_jump, pointer_call: begin
               {we, m, n} = {9'h000, o == pointer_jump ? 32'd2 : 32'd3};
               ep = o == relative_call ? pc + k : z;
            end
            equal_skip, skip_reg_bit_low, skip_io_bit_high: begin
               t = o == equal_skip ? a == b : o == skip_io_bit_high ?
                  io_data_in[bit_sel_in] : !b[bit_sel_in];
               {we, m, n} = {9'h000, t ? 32'd2 + next_two_word_in : 32'd1};
               ep = pc + 16'(n);
            end
            default: begin
               t = ef[bit_sel_in] == (o == branch_flag_high);
               {we, m, n} = {9'h000, t ? 32'd2 : 32'd1};
               ep = t ? pc + k : ep;
            end
         endcase
         if (o inside {[const_conjunction:zero_sign_check]}) begin
            {m, nf} = {8'h0E, 5'h00, r[7], r[7:0] == 8'h00, 1'b0};
         end
         ef = (ef & ~m) | (nf & m);
         `CHK("cycles", n, cyc)
         `CHK("pc", ep, pc_out)
         `CHK("io_addr", io_addr_in, io_addr_out)
         if (o inside {relative_call, pointer_call})
            `CHK("ret", pc + 16'h0001, ret_addr_out)
         `CHK("flags", ef, flags_out)
         `CHK("write", we, wr_en_out)
         if (we) `CHK("data", r[7:0], lo)
         if (we) `CHK("addr", d | 5'(m == 8'h1F), wr_addr_out)
         if (m == 8'h1F) `CHK("data_hi", r[15:8], wr_data_out)
         pc = ep;
      end
      print_verdict();
   end
endmodule : tb_alu_and_branch_execute
